// File: logic/ring_detect_pkg.sv
// Purpose: Shared constants for the ring detect monitor
// Assumes: 100 MHz system clock, AXI4-Lite with 32-bit data
// Notes:   Register offsets are byte addresses
`default_nettype none
package ring_detect_pkg;
	localparam int unsigned CLK_HZ       = 100_000_000;
	localparam int unsigned CYC_PER_MS   = CLK_HZ / 1000;
	localparam int unsigned ONESHOT_MS   = 5000;
	localparam int unsigned ONESHOT_CYC  = ONESHOT_MS * CYC_PER_MS;
	// Length of one ring timeout step
	localparam int unsigned RTO_STEP_MS  = 128;
	localparam int unsigned RTO_STEP_CYC = RTO_STEP_MS * CYC_PER_MS;

	localparam logic [7:0] A_THR_CTRL  = 8'h00;
	localparam logic [7:0] A_DET_CTRL  = 8'h04;
	localparam logic [7:0] A_PIN_CTRL  = 8'h08;
	localparam logic [7:0] A_IRQ_CTRL  = 8'h0c;
	localparam logic [7:0] A_IRQ_MASK  = 8'h10;
	localparam logic [7:0] A_IRQ_FLAG  = 8'h14;
	localparam logic [7:0] A_STATUS    = 8'h18;
	localparam logic [7:0] A_LINE_CTRL = 8'h1c;
	localparam logic [7:0] A_RTO_CTRL  = 8'h20;

	localparam int B_THR_LO   = 0;
	localparam int B_FWE      = 1;
	localparam int B_THR_HI   = 4;
	localparam int B_RING_PIN_POLARITY     = 1;
	localparam int B_DUAL     = 2;
	localparam int B_IPOL     = 6;
	localparam int B_IEN      = 7;
	localparam int B_MASK     = 7;
	localparam int B_FLAG     = 7;
	localparam int B_ST_POS   = 0;
	localparam int B_ST_NEG   = 1;
	localparam int B_ST_OS    = 2;
	localparam int B_OFFHOOK  = 0;
	localparam int B_MONITOR  = 1;
	localparam int B_PDL      = 2;
	localparam int B_RTO_LO   = 3;
	localparam int B_RTO_HI   = 6;

	localparam logic [15:0] PCM_POS_FS = 16'h7fff;
	localparam logic [15:0] PCM_NEG_FS = 16'h8000;
	localparam logic [15:0] PCM_MID_FW = 16'h04cc;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// File: logic/ring_detect_monitor.sv
// Purpose: Ring detection logic with status, indicator pin, interrupt and PCM substitution
// Assumes: Comparator inputs are asynchronous; host is an AXI4-Lite master
// Notes:   All state sits in one struct registered once per clock
// Behaviour
// RL1 - Full-wave enable 0 (reset) gives half-wave: only positive excursions detected.
// RL2 - Full-wave enable 1 detects positive and negative excursions.
// RL3 - Threshold chosen by bit 0 of one register and bit 4 of another.
// RL4 - Ring indicator pin active low; bit 1 polarity select makes it active high.
// RL5 - Half-wave: indicator asserts only above positive threshold.
// RL6 - Full-wave: indicator asserts above positive or below negative threshold.
// RL7 - Positive status bit is 1 while above positive threshold, any mode.
// RL8 - Negative status bit is 1 while below negative threshold, any mode.
// RL9 - Between thresholds both status bits read 0.
// RL10 - One-shot triggered by positive excursion, or either excursion in full-wave.
// RL11 - Each detection restarts one-shot counter; bit clears after about 5 s.
// RL12 - Off-hook forces the one-shot bit to 0.
// RL13 - Mask bit 7 set: interrupt pin raised when one-shot triggers.
// RL14 - Host clears pending ring interrupt by writing flag bit 7.
// RL15 - Dual-edge bit 2: interrupt at start and end of pulse; end from timeout 6:3.
// RL16 - Link powered, not off-hook, not monitoring: substitute ring data for samples.
// RL17 - Half-wave sample: 0x8000 unless above positive threshold, then 0x7fff.
// RL18 - Full-wave sample: 1228 between, 0x7fff above, 0x8000 below thresholds.
// RL19 - Sample MSB toggles at ring frequency in either mode.
// RL20 - Dual-edge interrupt works while ring validation is enabled.
// RL21 - Interrupt pin acts only when enabled; active low unless polarity bit set.
// RL22 - Threshold comparisons synchronised before use.
`default_nettype none
module ring_detect_monitor #(
	parameter int unsigned ONESHOT_CYC  = ring_detect_pkg::ONESHOT_CYC,
	parameter int unsigned RTO_STEP_CYC = ring_detect_pkg::RTO_STEP_CYC
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Threshold comparators and threshold select
	input  wire logic        ring_input_pos,
	input  wire logic        ring_input_neg,
	output logic             ring_threshold_sel,
	output logic             ring_threshold_sel_hi,
	// Open-drain pins, oe low while pulling low
	output logic             ring_indicator_pin_o,
	output logic             ring_indicator_pin_oe,
	output logic             irq_or_analog_out_pin_o,
	output logic             irq_or_analog_out_pin_oe,
	// Transmit PCM stream
	input  wire logic [15:0] pcm_in,
	output logic [15:0]      tx_pcm_samples,
	output logic             tx_pcm_ring_active
);
	typedef struct packed {
		logic [2:0]  sp;
		logic [2:0]  sn;
		logic        pos;
		logic        neg;
		logic        thr_lo;
		logic        thr_hi;
		logic        fwe;
		logic        ring_pin_polarity;
		logic        dual;
		logic        ipol;
		logic        ien;
		logic        mask;
		logic        flag;
		logic        off_hook;
		logic        monitor;
		logic        link_power_down;
		logic [3:0]  ring_end_timeout;
		logic [31:0] os_cnt;
		logic        os;
		logic [31:0] env_cnt;
		logic        env;
		logic        ring_oe;
		logic        irq_oe;
		logic        pin_lo;
		logic [15:0] pcm;
		logic        sub;
		logic        aw_got;
		logic [7:0]  aw_addr;
		logic        w_got;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} state_t;

	state_t s_r, s_nxt;

	logic det;
	logic do_wr;
	logic clr;
	logic ev;
	logic wr_hit;
	logic rd_hit;
	logic [7:0] wb;
	logic [7:0] rb;

	always_comb begin
		s_nxt = s_r;
		// Three-stage synchroniser; a change counts once stages 2 and 3 agree
		s_nxt.sp = {s_r.sp[1:0], ring_input_pos}; // RL22
		s_nxt.sn = {s_r.sn[1:0], ring_input_neg}; // RL22
		if (s_r.sp[1] == s_r.sp[2]) begin
			s_nxt.pos = s_r.sp[2]; // RL7
		end
		if (s_r.sn[1] == s_r.sn[2]) begin
			s_nxt.neg = s_r.sn[2]; // RL8
		end
		det = s_r.pos | (s_r.fwe & s_r.neg); // RL1 RL2 RL10

		// One-shot: reloaded while detecting, cleared by off-hook
		if (s_r.off_hook) begin
			s_nxt.os = 1'b0; // RL12
			s_nxt.os_cnt = '0;
		end else if (det) begin
			s_nxt.os = 1'b1; // RL10
			s_nxt.os_cnt = ONESHOT_CYC; // RL11
		end else if (s_r.os_cnt > 32'h1) begin
			s_nxt.os_cnt = s_r.os_cnt - 32'h1;
		end else begin
			s_nxt.os_cnt = '0;
			s_nxt.os = 1'b0; // RL11
		end

		// Pulse envelope ends a timeout after the last detection
		if (det) begin
			s_nxt.env = 1'b1;
			s_nxt.env_cnt = 32'(s_r.ring_end_timeout) * RTO_STEP_CYC; // RL15
		end else if (s_r.env_cnt != '0) begin
			s_nxt.env_cnt = s_r.env_cnt - 32'h1;
		end else begin
			s_nxt.env = 1'b0; // RL15
		end

		// Dual-edge takes both envelope edges, independent of validation
		ev = s_r.dual ? (s_nxt.env != s_r.env) : (s_nxt.os & ~s_r.os); // RL13 RL15 RL20

		// Bus write path
		wr_hit = 1'b0;
		rd_hit = 1'b0;
		rb = '0;
		clr = 1'b0;
		if (s_axi_awvalid && s_r.awready) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_r.wready) begin
			s_nxt.w_got = 1'b1;
			s_nxt.w_data = s_axi_wdata;
			s_nxt.w_strb = s_axi_wstrb;
		end
		do_wr = s_r.aw_got & s_r.w_got & ~s_r.bvalid;
		wb = s_r.w_data[7:0];
		if (do_wr) begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.bvalid = 1'b1;
			wr_hit = 1'b1;
			unique case (s_r.aw_addr)
				ring_detect_pkg::A_THR_CTRL: begin
					if (s_r.w_strb[0]) begin
						s_nxt.thr_lo = wb[ring_detect_pkg::B_THR_LO]; // RL3
					end
				end
				ring_detect_pkg::A_DET_CTRL: begin
					if (s_r.w_strb[0]) begin
						s_nxt.fwe = wb[ring_detect_pkg::B_FWE];
						s_nxt.thr_hi = wb[ring_detect_pkg::B_THR_HI]; // RL3
					end
				end
				ring_detect_pkg::A_PIN_CTRL: begin
					if (s_r.w_strb[0]) begin
						s_nxt.ring_pin_polarity = wb[ring_detect_pkg::B_RING_PIN_POLARITY]; // RL4
					end
				end
				ring_detect_pkg::A_IRQ_CTRL: begin
					if (s_r.w_strb[0]) begin
						s_nxt.dual = wb[ring_detect_pkg::B_DUAL];
						s_nxt.ipol = wb[ring_detect_pkg::B_IPOL];
						s_nxt.ien = wb[ring_detect_pkg::B_IEN];
					end
				end
				ring_detect_pkg::A_IRQ_MASK: begin
					if (s_r.w_strb[0]) begin
						s_nxt.mask = wb[ring_detect_pkg::B_MASK];
					end
				end
				ring_detect_pkg::A_IRQ_FLAG: begin
					clr = s_r.w_strb[0] & ~wb[ring_detect_pkg::B_FLAG]; // RL14
				end
				ring_detect_pkg::A_STATUS: begin
				end
				ring_detect_pkg::A_LINE_CTRL: begin
					if (s_r.w_strb[0]) begin
						s_nxt.off_hook = wb[ring_detect_pkg::B_OFFHOOK];
						s_nxt.monitor = wb[ring_detect_pkg::B_MONITOR];
						s_nxt.link_power_down = wb[ring_detect_pkg::B_PDL];
					end
				end
				ring_detect_pkg::A_RTO_CTRL: begin
					if (s_r.w_strb[0]) begin
						s_nxt.ring_end_timeout = wb[ring_detect_pkg::B_RTO_HI:ring_detect_pkg::B_RTO_LO];
					end
				end
				default: wr_hit = 1'b0;
			endcase
			s_nxt.bresp = wr_hit ? ring_detect_pkg::RESP_OKAY : ring_detect_pkg::RESP_SLVERR;
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		s_nxt.awready = ~s_nxt.aw_got & ~s_nxt.bvalid;
		s_nxt.wready = ~s_nxt.w_got & ~s_nxt.bvalid;

		// A new event beats a clear in the same cycle
		s_nxt.flag = ev | (s_r.flag & ~clr); // RL13 RL14

		// Bus read path
		if (s_axi_arvalid && s_r.arready) begin
			rd_hit = 1'b1;
			unique case (s_axi_araddr)
				ring_detect_pkg::A_THR_CTRL: rb[ring_detect_pkg::B_THR_LO] = s_r.thr_lo;
				ring_detect_pkg::A_DET_CTRL: begin
					rb[ring_detect_pkg::B_FWE] = s_r.fwe;
					rb[ring_detect_pkg::B_THR_HI] = s_r.thr_hi;
				end
				ring_detect_pkg::A_PIN_CTRL: rb[ring_detect_pkg::B_RING_PIN_POLARITY] = s_r.ring_pin_polarity;
				ring_detect_pkg::A_IRQ_CTRL: begin
					rb[ring_detect_pkg::B_DUAL] = s_r.dual;
					rb[ring_detect_pkg::B_IPOL] = s_r.ipol;
					rb[ring_detect_pkg::B_IEN] = s_r.ien;
				end
				ring_detect_pkg::A_IRQ_MASK: rb[ring_detect_pkg::B_MASK] = s_r.mask;
				ring_detect_pkg::A_IRQ_FLAG: rb[ring_detect_pkg::B_FLAG] = s_r.flag;
				ring_detect_pkg::A_STATUS: begin
					rb[ring_detect_pkg::B_ST_POS] = s_r.pos; // RL7 RL9
					rb[ring_detect_pkg::B_ST_NEG] = s_r.neg; // RL8 RL9
					rb[ring_detect_pkg::B_ST_OS] = s_r.os;
				end
				ring_detect_pkg::A_LINE_CTRL: begin
					rb[ring_detect_pkg::B_OFFHOOK] = s_r.off_hook;
					rb[ring_detect_pkg::B_MONITOR] = s_r.monitor;
					rb[ring_detect_pkg::B_PDL] = s_r.link_power_down;
				end
				ring_detect_pkg::A_RTO_CTRL: rb[ring_detect_pkg::B_RTO_HI:ring_detect_pkg::B_RTO_LO] = s_r.ring_end_timeout;
				default: rd_hit = 1'b0;
			endcase
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata = {24'h0, rb};
			s_nxt.rresp = rd_hit ? ring_detect_pkg::RESP_OKAY : ring_detect_pkg::RESP_SLVERR;
		end else if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		s_nxt.arready = ~s_nxt.rvalid;

		// Open-drain pins: o is always 0; polarity selects whether the asserted state pulls low or releases
		s_nxt.pin_lo = 1'b0;
		s_nxt.ring_oe = ~(det ^ s_r.ring_pin_polarity); // RL4 RL5 RL6
		s_nxt.irq_oe = s_r.ien ? ~((s_nxt.flag & s_r.mask) ^ s_r.ipol) : 1'b1; // RL13 RL21

		// Ring data replaces samples; MSB is 0 on positive excursions, 1 on negative ones
		s_nxt.sub = ~s_r.link_power_down & ~s_r.off_hook & ~s_r.monitor; // RL16
		if (!s_nxt.sub) begin
			s_nxt.pcm = pcm_in;
		end else if (s_r.pos) begin
			s_nxt.pcm = ring_detect_pkg::PCM_POS_FS; // RL17 RL18 RL19
		end else if (!s_r.fwe || s_r.neg) begin
			s_nxt.pcm = ring_detect_pkg::PCM_NEG_FS; // RL17 RL18 RL19
		end else begin
			s_nxt.pcm = ring_detect_pkg::PCM_MID_FW; // RL18
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_r <= '0;
			s_r.ring_oe <= 1'b1;
			s_r.irq_oe <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign s_axi_awready            = s_r.awready;
	assign s_axi_wready             = s_r.wready;
	assign s_axi_bvalid             = s_r.bvalid;
	assign s_axi_bresp              = s_r.bresp;
	assign s_axi_arready            = s_r.arready;
	assign s_axi_rvalid             = s_r.rvalid;
	assign s_axi_rdata              = s_r.rdata;
	assign s_axi_rresp              = s_r.rresp;
	assign ring_threshold_sel       = s_r.thr_lo;
	assign ring_threshold_sel_hi    = s_r.thr_hi;
	assign ring_indicator_pin_o     = s_r.pin_lo;
	assign ring_indicator_pin_oe    = s_r.ring_oe;
	assign irq_or_analog_out_pin_o  = s_r.pin_lo;
	assign irq_or_analog_out_pin_oe = s_r.irq_oe;
	assign tx_pcm_samples           = s_r.pcm;
	assign tx_pcm_ring_active       = s_r.sub;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_sync_settle: assert property ((s_r.sp[1] == s_r.sp[2]) |=> s_r.pos == $past(s_r.sp[2])) // RL22
		else $error("positive compare not taken after agreement");
	a_half_pin: assert property ((!s_r.fwe && !s_r.ring_pin_polarity && !s_r.pos && s_r.neg) |=> s_r.ring_oe) // RL5
		else $error("indicator asserted on negative in half-wave");
	a_full_pin: assert property ((s_r.fwe && s_r.ring_pin_polarity && s_r.neg) |=> s_r.ring_oe) // RL6
		else $error("indicator not asserted on negative in full-wave");
	a_pin_polarity: assert property ((s_r.pos && !s_r.ring_pin_polarity) |=> !s_r.ring_oe) // RL4
		else $error("active-low indicator not pulled low");
	a_oneshot_hook: assert property (s_r.off_hook |=> !s_r.os) // RL12
		else $error("one-shot survived off-hook");
	a_oneshot_trig: assert property ((s_r.fwe && s_r.neg && !s_r.off_hook) // RL10
		|=> s_r.os ##1 (s_r.os || $past(s_r.off_hook)))
		else $error("one-shot not triggered by negative in full-wave");
	a_irq_raise: assert property (($rose(s_r.os) && !$past(s_r.dual) && s_r.mask && s_r.ien && !s_r.ipol
		&& $past(s_r.mask) && $past(s_r.ien) && $past(s_r.ipol) == 1'b0) |-> !s_r.irq_oe) // RL13
		else $error("interrupt pin not raised on one-shot trigger");
	a_flag_sticky: assert property ((s_r.flag && !(do_wr && s_r.aw_addr == ring_detect_pkg::A_IRQ_FLAG))
		|=> s_r.flag) // RL14
		else $error("interrupt flag dropped without a clear");
	a_dual_end: assert property ((s_r.dual && $fell(s_r.env) && $past(s_r.dual)) |-> s_r.flag) // RL15
		else $error("no interrupt at pulse end");
	a_pcm_half: assert property ((s_nxt.sub && !s_r.fwe) |=> s_r.pcm == ($past(s_r.pos) ?
		ring_detect_pkg::PCM_POS_FS : ring_detect_pkg::PCM_NEG_FS)) // RL17
		else $error("half-wave ring sample wrong");
	a_pcm_full_mid: assert property ((s_nxt.sub && s_r.fwe && !s_r.pos && !s_r.neg)
		|=> s_r.pcm == ring_detect_pkg::PCM_MID_FW) // RL18
		else $error("full-wave idle sample wrong");
	a_pcm_pass: assert property ((s_r.off_hook || s_r.monitor || s_r.link_power_down) |=> !s_r.sub) // RL16
		else $error("substitution active while disallowed");
	a_sub_on: assert property ((!s_r.link_power_down && !s_r.off_hook && !s_r.monitor) |=> s_r.sub) // RL16
		else $error("substitution missing while allowed");
	a_pcm_full_neg: assert property ((s_nxt.sub && s_r.fwe && s_r.neg && !s_r.pos) // RL18
		|=> s_r.pcm == ring_detect_pkg::PCM_NEG_FS)
		else $error("full-wave negative sample wrong");
	a_irq_off: assert property (!s_r.ien |=> s_r.irq_oe) // RL21
		else $error("interrupt pin driven while disabled");
	a_oneshot_end: assert property ((!det && !s_r.off_hook && s_r.os_cnt == 32'h1) |=> !s_r.os) // RL11
		else $error("one-shot outlived its count");
	a_status_quiet: assert property ((s_axi_arvalid && s_r.arready && s_axi_araddr == ring_detect_pkg::A_STATUS // RL9
		&& !s_r.pos && !s_r.neg) |=> s_r.rdata[ring_detect_pkg::B_ST_NEG:ring_detect_pkg::B_ST_POS] == 2'h0)
		else $error("status bits set between thresholds");

	c_ring_half: cover property (!s_r.fwe && s_r.sub && $rose(s_r.pos));
	c_ring_full_neg: cover property (s_r.fwe && s_r.sub && $rose(s_r.neg));
	c_irq_clear: cover property (s_r.flag ##1 !s_r.flag);
	c_dual_end: cover property (s_r.dual && $fell(s_r.env));
endmodule // ring_detect_monitor
`default_nettype wire

// File: tb/ring_line_model.sv
// Purpose: Line side of the ring detector: comparator levels and pin pull-ups
// Assumes: Both open-drain pins have a pull-up on the board
// Notes:   phase 0 between thresholds, 1 above positive, 2 below negative
`default_nettype none
module ring_line_model (
	// Line state
	input  wire logic [1:0] phase,
	output logic            ring_input_pos,
	output logic            ring_input_neg,
	// Open-drain pins
	input  wire logic       rp_o,
	input  wire logic       rp_oe,
	input  wire logic       ip_o,
	input  wire logic       ip_oe,
	output wire logic       ring_pin,
	output wire logic       irq_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// Both comparators can never be high together on a real line
	assign ring_input_pos = (phase == 2'h1);
	assign ring_input_neg = (phase == 2'h2);
	assign ring_pin       = rp_oe ? 1'b1 : rp_o;
	assign irq_pin        = ip_oe ? 1'b1 : ip_o;
endmodule // ring_line_model
`default_nettype wire

// File: tb/ring_detect_monitor_tb.sv
// Purpose: Self-checking bench for the ring detect monitor
// Assumes: Short one-shot and timeout step parameters
// Notes:   Waits of 6 cycles cover the synchroniser and output register
`default_nettype none
module ring_detect_monitor_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned OS = 50;
	logic        clk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, pos, neg, sel, sel_hi;
	logic        rp_o, rp_oe, ip_o, ip_oe, ring_pin, irq_pin, act;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r, phase;
	logic [15:0] pcm_in, pcm;
	int          n_mismatch, n_checks;
	ring_detect_monitor #(.ONESHOT_CYC(OS), .RTO_STEP_CYC(10)) ring_detect_monitor_inst (.clk(clk), .rstn(rstn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .ring_input_pos(pos), .ring_input_neg(neg), .ring_threshold_sel(sel),
		.ring_threshold_sel_hi(sel_hi), .ring_indicator_pin_o(rp_o), .ring_indicator_pin_oe(rp_oe),
		.irq_or_analog_out_pin_o(ip_o), .irq_or_analog_out_pin_oe(ip_oe), .pcm_in(pcm_in),
		.tx_pcm_samples(pcm), .tx_pcm_ring_active(act));
	ring_line_model ring_line_model_inst (.phase(phase), .ring_input_pos(pos), .ring_input_neg(neg),
		.rp_o(rp_o), .rp_oe(rp_oe), .ip_o(ip_o), .ip_oe(ip_oe), .ring_pin(ring_pin), .irq_pin(irq_pin));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic aw_d, w_d;
		aw_d = 1'b0;
		w_d  = 1'b0;
		awaddr  <= a;
		awvalid <= 1'b1;
		wdata   <= {24'h0, v};
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (!(aw_d && w_d)) begin
			@(posedge clk);
			if (awvalid && awready === 1'b1) begin
				awvalid <= 1'b0;
				aw_d = 1'b1;
			end
			if (wvalid && wready === 1'b1) begin
				wvalid <= 1'b0;
				w_d = 1'b1;
			end
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic ph(input logic [1:0] p, input int n);
		phase <= p;
		repeat (n) @(posedge clk);
	endtask
	task automatic t_regs();
		wr(ring_detect_pkg::A_THR_CTRL, 8'h01);
		chk(sel === 1'b1 && r === ring_detect_pkg::RESP_OKAY, "threshold low select");
		wr(ring_detect_pkg::A_DET_CTRL, 8'h10);
		chk(sel_hi === 1'b1, "threshold high select");
		wr(8'hfc, 8'hff);
		chk(r === ring_detect_pkg::RESP_SLVERR, "unmapped write resp");
		rd(8'hfc);
		chk(r === ring_detect_pkg::RESP_SLVERR && d === 32'h0, "unmapped read");
		wr(ring_detect_pkg::A_THR_CTRL, 8'h00);
		wr(ring_detect_pkg::A_DET_CTRL, 8'h00);
		chk(sel === 1'b0 && sel_hi === 1'b0, "threshold selects cleared");
		wstrb <= 4'he;
		wr(ring_detect_pkg::A_THR_CTRL, 8'h01);
		chk(sel === 1'b0 && r === ring_detect_pkg::RESP_OKAY, "lane 0 off leaves select");
		wstrb <= 4'hf;
	endtask
	task automatic t_line();
		wr(ring_detect_pkg::A_LINE_CTRL, 8'h02);
		chk(act === 1'b0 && pcm === pcm_in, "monitor passes samples");
		wr(ring_detect_pkg::A_LINE_CTRL, 8'h04);
		chk(act === 1'b0 && pcm === pcm_in, "link down passes samples");
		wr(ring_detect_pkg::A_LINE_CTRL, 8'h00);
		chk(act === 1'b1 && pcm === ring_detect_pkg::PCM_NEG_FS, "substitution resumes");
	endtask
	task automatic t_half();
		ph(2'h2, 6);
		rd(ring_detect_pkg::A_STATUS);
		chk(d[2:0] === 3'h2 && ring_pin === 1'b1, "half mode ignores negative");
		chk(pcm === ring_detect_pkg::PCM_NEG_FS && act === 1'b1, "half negative sample");
		ph(2'h1, 6);
		rd(ring_detect_pkg::A_STATUS);
		chk(d[2:0] === 3'h5 && ring_pin === 1'b0, "half positive detect");
		chk(pcm === ring_detect_pkg::PCM_POS_FS && pcm[15] === 1'b0, "half positive sample");
		ph(2'h0, 6);
		rd(ring_detect_pkg::A_STATUS);
		chk(d[1:0] === 2'h0 && ring_pin === 1'b1, "between thresholds");
		chk(pcm === ring_detect_pkg::PCM_NEG_FS && pcm[15] === 1'b1, "half idle sample");
	endtask
	task automatic t_full();
		wr(ring_detect_pkg::A_DET_CTRL, 8'h02);
		chk(pcm === ring_detect_pkg::PCM_MID_FW, "full idle sample");
		ph(2'h2, 6);
		chk(ring_pin === 1'b0 && pcm === ring_detect_pkg::PCM_NEG_FS, "full negative detect");
		rd(ring_detect_pkg::A_STATUS);
		chk(d[2:0] === 3'h6, "full negative status");
		ph(2'h1, 6);
		chk(ring_pin === 1'b0 && pcm === ring_detect_pkg::PCM_POS_FS, "full positive detect");
		ph(2'h0, 6);
		chk(ring_pin === 1'b1, "full idle pin");
		wr(ring_detect_pkg::A_PIN_CTRL, 8'h02);
		chk(ring_pin === 1'b0, "active high pin idle");
		ph(2'h1, 6);
		chk(ring_pin === 1'b1, "active high pin detect");
		ph(2'h0, 6);
		wr(ring_detect_pkg::A_PIN_CTRL, 8'h00);
		wr(ring_detect_pkg::A_DET_CTRL, 8'h00);
	endtask
	task automatic t_oneshot();
		wr(ring_detect_pkg::A_LINE_CTRL, 8'h01);
		rd(ring_detect_pkg::A_STATUS);
		chk(d[2] === 1'b0, "off-hook clears one-shot");
		chk(act === 1'b0 && pcm === pcm_in, "off-hook passes samples");
		wr(ring_detect_pkg::A_LINE_CTRL, 8'h00);
		ph(2'h1, 2);
		ph(2'h0, 35);
		ph(2'h1, 2);
		ph(2'h0, 35);
		rd(ring_detect_pkg::A_STATUS);
		chk(d[2] === 1'b1, "one-shot restarted");
		repeat (OS) @(posedge clk);
		rd(ring_detect_pkg::A_STATUS);
		chk(d[2] === 1'b0, "one-shot expired");
	endtask
	task automatic t_irq();
		wr(ring_detect_pkg::A_IRQ_FLAG, 8'h00);
		wr(ring_detect_pkg::A_IRQ_MASK, 8'h80);
		wr(ring_detect_pkg::A_IRQ_CTRL, 8'h80);
		chk(irq_pin === 1'b1, "no interrupt pending");
		ph(2'h1, 6);
		chk(irq_pin === 1'b0, "ring interrupt");
		ph(2'h0, 1);
		wr(ring_detect_pkg::A_IRQ_FLAG, 8'h00);
		chk(irq_pin === 1'b1, "interrupt cleared");
		wr(ring_detect_pkg::A_IRQ_CTRL, 8'hc0);
		chk(irq_pin === 1'b0, "active high interrupt idle");
		wr(ring_detect_pkg::A_LINE_CTRL, 8'h01);
		wr(ring_detect_pkg::A_LINE_CTRL, 8'h00);
		wr(ring_detect_pkg::A_RTO_CTRL, 8'h10);
		wr(ring_detect_pkg::A_IRQ_CTRL, 8'h84);
		ph(2'h1, 6);
		chk(irq_pin === 1'b0, "dual edge start");
		wr(ring_detect_pkg::A_IRQ_FLAG, 8'h00);
		chk(irq_pin === 1'b1, "dual edge start cleared");
		ph(2'h0, 12);
		chk(irq_pin === 1'b1, "envelope still open");
		repeat (20) @(posedge clk);
		chk(irq_pin === 1'b0, "dual edge end");
		wr(ring_detect_pkg::A_IRQ_CTRL, 8'h00);
		chk(irq_pin === 1'b1, "interrupt pin disabled");
		wr(ring_detect_pkg::A_IRQ_MASK, 8'h00);
		wr(ring_detect_pkg::A_IRQ_CTRL, 8'h80);
		wr(ring_detect_pkg::A_LINE_CTRL, 8'h01);
		wr(ring_detect_pkg::A_LINE_CTRL, 8'h00);
		wr(ring_detect_pkg::A_IRQ_FLAG, 8'h00);
		ph(2'h1, 6);
		chk(irq_pin === 1'b1, "masked ring leaves pin idle");
		rd(ring_detect_pkg::A_IRQ_FLAG);
		chk(d === 32'h80, "flag set while masked");
	endtask
	initial begin
		#300000;
		n_mismatch++;
		close_out();
	end
	initial begin
		rstn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{awaddr, araddr, wdata} = '0;
		wstrb  = 4'hf;
		phase  = 2'h0;
		pcm_in = 16'h1234;
		n_mismatch = 0;
		n_checks = 0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		rd(ring_detect_pkg::A_DET_CTRL);
		chk(d === 32'h0 && ring_pin === 1'b1 && irq_pin === 1'b1, "reset state");
		t_regs();
		t_half();
		t_full();
		t_oneshot();
		t_line();
		t_irq();
		close_out();
	end
endmodule // ring_detect_monitor_tb
`default_nettype wire
